/* rtl/fci_pkg.sv */
package fci_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;     // 100 MHz mclk
    localparam int ERASE_TIME_NS = 4000000; // Longest sector erase
    localparam int PROG_TIME_NS = 35000;    // Longest byte program
    // Longest times round down to whole cycles
    localparam int ERASE_CYC = ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int SETUP_NS = 20;           // Address before strobe
    localparam int STROBE_NS = 240;         // Strobe low, covers access
    localparam int HOLD_NS = 20;            // Address/data after strobe
    // Least times round up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POLL_MARGIN_CYC = 64;    // Slack past the longest time

    // ------------------------------------------------------------
    // Command bytes and fixed addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_EXEC = 8'hd0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h10;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [18:0] ID_BASE_ADDR = 19'h00000; // Maker; +1 part
    localparam logic [18:0] ANY_ADDR = 19'h00000;     // Don't-care address
    localparam int SECTOR_LSB = 8;                    // Sector = bits 18:8

    // ------------------------------------------------------------
    // Sequence step indices and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] STEP_FIRST = 4'h0;
    localparam logic [3:0] STEP_SETUP = 4'h7;  // After seven unlock reads
    localparam logic [3:0] STEP_EXEC = 4'h8;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [31:0] TMO_RST = 32'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE = 3'h2,
        OP_RESET = 3'h3,
        OP_READ_ID = 3'h4
    } fci_op_type;

    typedef struct packed {
        fci_op_type op;     // Operation requested
        logic [18:0] addr;  // Target byte_address
        logic [7:0] data;   // program_value
    } fci_req_type;

    typedef struct packed {
        logic wr;           // Write cycle, else read
        logic [18:0] addr;
        logic [7:0] data;
        logic last;         // Final cycle of the sequence
    } fci_cyc_type;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [18:0] byte_address;
        logic [7:0] data_bus_out;
        logic data_bus_oe;  // High while the host drives data_bus
    } fci_pins_type;

    localparam fci_pins_type PINS_RST = '{ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, byte_address: 19'h0, data_bus_out: 8'h0,
        data_bus_oe: 1'b0};

    // Fixed read order that lifts soft_write_lock
    function automatic logic [18:0] unlock_addr(input logic [3:0] idx);
        case (idx)
            4'h0: unlock_addr = 19'h01823;
            4'h1: unlock_addr = 19'h01820;
            4'h2: unlock_addr = 19'h01822;
            4'h3: unlock_addr = 19'h00418;
            4'h4: unlock_addr = 19'h0041b;
            4'h5: unlock_addr = 19'h00419;
            default: unlock_addr = 19'h0041a;
        endcase
    endfunction

endpackage

/* rtl/fci_bus_cycle.sv */
`timescale 1ns/1ns
module fci_bus_cycle (
    input wire logic mclk,                   // System clock
    input wire logic rstn,                   // Async reset, active low
    input wire logic start,                  // Begin one bus cycle
    input wire fci_pkg::fci_cyc_type cyc,    // Cycle description
    input wire logic [7:0] data_bus_in,      // data_bus pin level
    output fci_pkg::fci_pins_type pins,      // Registered flash pins
    output logic done,                       // One-cycle end pulse
    output logic [7:0] rdata                 // Byte captured on reads
);

    // ------------------------------------------------------------
    // Phases, Gray coded along setup, strobe, hold
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SETUP = 2'b01,
        PH_STROBE = 2'b11,
        PH_HOLD = 2'b10
    } fci_phase_type;

    fci_phase_type ph_ff;       // Current phase
    logic [7:0] cnt_ff;         // Cycles left in phase
    logic wr_ff;                // Cycle is a write
    logic [7:0] sync1_ff;       // First synchroniser stage only
    logic [7:0] sync2_ff;       // Safe copy of data_bus
    wire cnt_zero = (cnt_ff == 8'h00);

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= fci_pkg::DATA_RST;
            sync2_ff <= fci_pkg::DATA_RST;
        end else begin
            sync1_ff <= data_bus_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ------------------------------------------------------------
    // Phase sequencer and pins
    // ------------------------------------------------------------
    // Address stays put from setup to hold, so it is stable across
    // both the late falling edge and the early rising edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ph_ff <= PH_IDLE;
            cnt_ff <= 8'h00;
            wr_ff <= 1'b0;
            pins <= fci_pkg::PINS_RST;
            done <= 1'b0;
            rdata <= fci_pkg::DATA_RST;
        end else begin
            done <= 1'b0;
            case (ph_ff)
                PH_IDLE: begin
                    if (start) begin
                        // Select chip, present address; drive data
                        // only for writes, with oe_n held high
                        ph_ff <= PH_SETUP;
                        cnt_ff <= 8'(fci_pkg::SETUP_CYC - 1);
                        wr_ff <= cyc.wr;
                        pins.ce_n <= 1'b0;
                        pins.byte_address <= cyc.addr;
                        pins.data_bus_out <= cyc.data;
                        pins.data_bus_oe <= cyc.wr;
                    end
                end
                PH_SETUP: begin
                    if (cnt_zero) begin
                        ph_ff <= PH_STROBE;
                        cnt_ff <= 8'(fci_pkg::STROBE_CYC - 1);
                        // Write is ce low, oe high, we low only
                        pins.we_n <= !wr_ff;
                        pins.oe_n <= wr_ff;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                PH_STROBE: begin
                    if (cnt_zero) begin
                        // Rising strobe latches data; sample before it
                        ph_ff <= PH_HOLD;
                        cnt_ff <= 8'(fci_pkg::HOLD_CYC - 1);
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        if (!wr_ff) begin
                            rdata <= sync2_ff;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                default: begin
                    if (cnt_zero) begin
                        // Deselect: device returns to standby
                        ph_ff <= PH_IDLE;
                        pins.ce_n <= 1'b1;
                        pins.data_bus_oe <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_write_pulse;
        (!pins.we_n && pins.oe_n && !pins.ce_n) [*8];
    endsequence

    a_write_form:
    assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n)
        else $error("write strobe without ce low and oe high");
    a_bus_release:
    assert property (!pins.oe_n |-> !pins.data_bus_oe)
        else $error("host drives data while output enabled");
    a_write_pulse:
    assert property ($fell(pins.we_n) |-> s_write_pulse)
        else $error("write pulse too short");
    a_addr_stable:
    assert property (!pins.ce_n && !$past(pins.ce_n)
        |-> $stable(pins.byte_address))
        else $error("address moved while selected");
    a_data_hold:
    assert property ($rose(pins.we_n) |-> pins.data_bus_oe
        && $stable(pins.data_bus_out) ##1 !pins.ce_n)
        else $error("data not held across write rise");

endmodule

/* rtl/fci_flash_host.sv */
`timescale 1ns/1ns
module fci_flash_host #(
    parameter int ERASE_CYC = fci_pkg::ERASE_CYC, // Erase limit
    parameter int PROG_CYC = fci_pkg::PROG_CYC    // Program limit
) (
    input wire logic mclk,                      // System clock
    input wire logic rstn,                      // Async reset, active low
    input wire logic req_valid,                 // Request offered
    input wire fci_pkg::fci_req_type req,       // Request contents
    output logic req_ready,                     // Idle, takes a request
    input wire logic abort,                     // Abandon busy wait
    output logic resp_valid,                    // One-cycle completion
    output logic [7:0] resp_data,               // Last byte read
    output logic resp_err,                      // Timed out or aborted
    input wire logic [7:0] data_bus_in,         // data_bus pin level
    output fci_pkg::fci_pins_type flash_pins    // Flash pins
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11,
        ST_FINISH = 2'b10
    } fci_state_type;

    fci_state_type st_ff;        // Sequencer state
    fci_pkg::fci_op_type op_ff;  // Operation in progress
    logic [18:0] addr_ff;        // Target address
    logic [7:0] data_ff;         // Byte to program
    logic [3:0] step_ff;         // Cycle index within sequence
    logic polling_ff;            // Waiting for self-timed end
    logic have_prev_ff;          // A poll read already seen
    logic [7:0] prev_ff;         // Previous poll read
    logic [7:0] rd_ff;           // Last byte read
    logic [31:0] tmo_ff;         // Cycles spent polling
    logic abort_ff;              // Abort seen while busy
    logic err_ff;                // Ended by reset, not completion
    logic eng_done;              // Bus cycle finished
    logic [7:0] eng_rdata;       // Bus cycle read byte

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    // Every erase and program opens with the unlock reads, so the
    // lock that power-up sets never refuses them
    function automatic fci_pkg::fci_cyc_type cyc_of(
        input fci_pkg::fci_op_type op, input logic [3:0] idx,
        input logic [18:0] a, input logic [7:0] d);
        fci_pkg::fci_cyc_type c;
        c = '{wr: 1'b0, addr: a, data: d, last: 1'b1};
        case (op)
            fci_pkg::OP_PROGRAM, fci_pkg::OP_ERASE: begin
                c.last = (idx == fci_pkg::STEP_EXEC);
                if (idx < fci_pkg::STEP_SETUP) begin
                    c.addr = fci_pkg::unlock_addr(idx);
                end else if (idx == fci_pkg::STEP_SETUP) begin
                    c.wr = 1'b1;
                    c.addr = fci_pkg::ANY_ADDR;
                    c.data = (op == fci_pkg::OP_ERASE) ?
                        fci_pkg::CMD_ERASE_SETUP : fci_pkg::CMD_PROG_SETUP;
                end else begin
                    c.wr = 1'b1;
                    if (op == fci_pkg::OP_ERASE) begin
                        // Low byte is don't care; sent as zero
                        c.addr = {a[18:fci_pkg::SECTOR_LSB],
                            8'h00};
                        c.data = fci_pkg::CMD_ERASE_EXEC;
                    end
                end
            end
            fci_pkg::OP_RESET: begin
                c.wr = 1'b1;
                c.addr = fci_pkg::ANY_ADDR;
                c.data = fci_pkg::CMD_RESET;
            end
            fci_pkg::OP_READ_ID: begin
                // 90h, one code read, then FFh back to read mode
                c.wr = (idx != 4'h1);
                c.last = (idx == 4'h2);
                c.addr = (idx == 4'h1) ? (fci_pkg::ID_BASE_ADDR |
                    {18'h0, a[0]}) : fci_pkg::ANY_ADDR;
                c.data = (idx == 4'h0) ? fci_pkg::CMD_READ_ID :
                    fci_pkg::CMD_RESET;
            end
            default: ;
        endcase
        return c;
    endfunction

    wire is_mod = (op_ff == fci_pkg::OP_PROGRAM) ||
        (op_ff == fci_pkg::OP_ERASE);
    wire fci_pkg::fci_cyc_type poll_cyc =
        '{wr: 1'b0, addr: addr_ff, data: data_ff, last: 1'b1};
    wire fci_pkg::fci_cyc_type cur = polling_ff ? poll_cyc :
        cyc_of(op_ff, step_ff, addr_ff, data_ff);
    wire eng_start = (st_ff == ST_ISSUE);
    wire [31:0] tmo_lim = (op_ff == fci_pkg::OP_ERASE) ?
        32'(ERASE_CYC) : 32'(PROG_CYC);
    wire tmo_hit = (tmo_ff >= tmo_lim);
    // Two equal reads: bit 6 stopped and bit 7 is true data
    wire poll_same = have_prev_ff && (prev_ff == eng_rdata);
    wire give_up = abort_ff || tmo_hit;

    fci_bus_cycle u_cycle (
        .mclk(mclk),
        .rstn(rstn),
        .start(eng_start),
        .cyc(cur),
        .data_bus_in(data_bus_in),
        .pins(flash_pins),
        .done(eng_done),
        .rdata(eng_rdata)
    );

    // ------------------------------------------------------------
    // Busy timer and abort capture
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tmo_ff <= fci_pkg::TMO_RST;
            abort_ff <= 1'b0;
        end else begin
            tmo_ff <= polling_ff ? tmo_ff + 32'h1 : fci_pkg::TMO_RST;
            abort_ff <= (st_ff != ST_IDLE) && (abort_ff || abort);
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= ST_IDLE;
            op_ff <= fci_pkg::OP_READ;
            addr_ff <= 19'h0;
            data_ff <= fci_pkg::DATA_RST;
            step_ff <= fci_pkg::STEP_FIRST;
            polling_ff <= 1'b0;
            have_prev_ff <= 1'b0;
            prev_ff <= fci_pkg::DATA_RST;
            rd_ff <= fci_pkg::DATA_RST;
            err_ff <= 1'b0;
            req_ready <= 1'b1;
            resp_valid <= 1'b0;
            resp_data <= fci_pkg::DATA_RST;
            resp_err <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            case (st_ff)
                ST_IDLE: begin
                    if (req_valid) begin
                        st_ff <= ST_ISSUE;
                        op_ff <= req.op;
                        addr_ff <= req.addr;
                        data_ff <= req.data;
                        step_ff <= fci_pkg::STEP_FIRST;
                        polling_ff <= 1'b0;
                        have_prev_ff <= 1'b0;
                        err_ff <= 1'b0;
                        req_ready <= 1'b0;
                    end
                end
                ST_ISSUE: st_ff <= ST_WAIT;
                ST_WAIT: begin
                    if (eng_done) begin
                        st_ff <= ST_ISSUE;
                        if (!cur.wr) begin
                            rd_ff <= eng_rdata;
                        end
                        if (polling_ff) begin
                            prev_ff <= eng_rdata;
                            have_prev_ff <= 1'b1;
                            if (poll_same) begin
                                st_ff <= ST_FINISH;
                            end else if (give_up) begin
                                // FFh write stops the operation
                                op_ff <= fci_pkg::OP_RESET;
                                step_ff <= fci_pkg::STEP_FIRST;
                                polling_ff <= 1'b0;
                                err_ff <= 1'b1;
                            end
                        end else if (cur.last) begin
                            if (is_mod) begin
                                polling_ff <= 1'b1;
                            end else begin
                                st_ff <= ST_FINISH;
                            end
                        end else begin
                            // Execute goes out right after setup
                            step_ff <= step_ff + 4'h1;
                        end
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                    resp_valid <= 1'b1;
                    resp_data <= rd_ff;
                    resp_err <= err_ff;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_idle_standby:
    assert property (st_ff == ST_IDLE && $past(st_ff) == ST_IDLE
        |-> flash_pins.ce_n)
        else $error("chip selected while idle");
    a_unlock_order:
    assert property (eng_start && is_mod && !polling_ff
        && step_ff < fci_pkg::STEP_SETUP
        |-> !cur.wr && cur.addr == fci_pkg::unlock_addr(step_ff))
        else $error("unlock read out of order");
    a_erase_exec:
    assert property (eng_start && op_ff == fci_pkg::OP_ERASE
        && !polling_ff && step_ff == fci_pkg::STEP_EXEC
        |-> cur.wr && cur.data == 8'hd0 && cur.addr[7:0] == 8'h00)
        else $error("erase execute malformed");
    a_prog_exec:
    assert property (eng_start && op_ff == fci_pkg::OP_PROGRAM
        && !polling_ff && step_ff == fci_pkg::STEP_EXEC
        |-> cur.wr && cur.addr == addr_ff && cur.data == data_ff)
        else $error("program execute malformed");
    a_setup_exec:
    assert property (eng_done && is_mod && !polling_ff
        && step_ff == fci_pkg::STEP_SETUP
        |=> st_ff == ST_ISSUE && step_ff == fci_pkg::STEP_EXEC)
        else $error("execute did not follow setup");
    a_id_addr:
    assert property (eng_start && op_ff == fci_pkg::OP_READ_ID
        && step_ff == 4'h1 |-> !cur.wr && cur.addr[18:1] == 18'h0)
        else $error("identifier read at wrong address");
    a_busy_bound:
    assert property (polling_ff
        |-> tmo_ff <= tmo_lim + 32'(fci_pkg::POLL_MARGIN_CYC))
        else $error("busy wait exceeded its limit");
    a_finish_resp:
    assert property (st_ff == ST_FINISH |=> resp_valid && req_ready
        ##1 !resp_valid)
        else $error("response not a single pulse");

endmodule

/* testbench/fci_flash_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Behavioural flash part on the far side
// ----------------------------------------
module fci_flash_model #(
    parameter logic [7:0] MAKER = 8'h5e, // Arbitrary value
    parameter logic [7:0] PART = 8'h21   // Arbitrary value
) (
    input wire logic ce_n,        // Chip select
    input wire logic oe_n,        // Output enable
    input wire logic we_n,        // Write enable
    input wire logic [18:0] addr, // byte_address
    input wire logic [7:0] din,   // data_bus from host
    output logic [7:0] dout,      // data_bus from part
    output logic doe              // Part drives data_bus
);
    logic [7:0] mem [int];        // Absent key reads as erased
    logic [18:0] ul [7] = '{19'h1823, 19'h1820, 19'h1822, 19'h418,
        19'h41b, 19'h419, 19'h41a};
    logic lock = 1'b1;            // Locked at power-up
    int mode = 0;                 // 0 read, 1 erase, 2 program, 3 id
    int k = 0;                    // Unlock reads matched so far
    logic [18:0] la;              // Latched write address
    logic [7:0] lw = 8'h00;       // Last written byte
    logic tg = 1'b0;              // Busy toggle
    time bt = 0;                  // End of self-timed work
    assign doe = !ce_n && !oe_n;
    // Read data fixed at the strobe; busy reads show status
    always @(negedge oe_n) if (!ce_n) begin
        if ($time < bt) dout = {~lw[7], tg, 6'h00};
        else if (mode == 3) dout = addr[0] ? PART : MAKER;
        else dout = mem.exists(addr) ? mem[addr] : 8'hff;
    end
    // Read end takes the address, so it sees the unlock order
    always @(posedge oe_n) if (!ce_n) begin
        tg = ~tg;
        k = (addr == ul[k]) ? k + 1 : (addr == ul[0]) ? 1 : 0;
        if (k == 7) lock = 1'b0;
        if (k == 7) k = 0;
    end
    always @(negedge we_n) if (!ce_n && oe_n) la = addr;
    // Command decode on the write's rising edge
    always @(posedge we_n) if (!ce_n && oe_n) begin
        lw = din;
        if (din == 8'hff) bt = 0;
        if (mode == 1 && din == 8'hd0 && !lock) begin
            for (int i = 0; i < 256; i++) mem.delete({la[18:8], 8'(i)});
            bt = $time + 1200;
            mode = 0;
        end else if (mode == 2) begin
            if (!lock) mem[la] = din;
            if (!lock) bt = $time + 500;
            mode = 0;
        end else if (mode == 1) mode = 0;
        else mode = din == 8'h20 ? 1 : din == 8'h10 ? 2 : din == 8'h90 ? 3 : 0;
    end
endmodule

/* testbench/flash_command_interface_bench.sv */
`timescale 1ns/1ns
module flash_command_interface_bench;
    localparam logic [7:0] MK = 8'h5e; // Arbitrary value
    localparam logic [7:0] PT = 8'h21; // Arbitrary value
    logic mclk = 0, rstn = 0, req_valid = 0, abort = 0;
    fci_pkg::fci_req_type req = '0;
    logic req_ready, resp_valid, resp_err, doe, er;
    logic [7:0] resp_data, dout, bus, rd;
    fci_pkg::fci_pins_type pins;
    int bad_count = 0, n_compared = 0, cyc = 0;
    // Undriven bus shows a pattern changing every cycle
    assign bus = pins.data_bus_oe ? pins.data_bus_out : doe ? dout : cyc[7:0];
    fci_flash_host #(.ERASE_CYC(200), .PROG_CYC(100)) dut (.mclk(mclk),
        .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .abort(abort), .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_err(resp_err), .data_bus_in(bus), .flash_pins(pins));
    fci_flash_model #(.MAKER(MK), .PART(PT)) part (.ce_n(pins.ce_n),
        .oe_n(pins.oe_n), .we_n(pins.we_n), .addr(pins.byte_address),
        .din(pins.data_bus_out), .dout(dout), .doe(doe));
    initial forever #5 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) bad_count++;
        if (cyc == 20000) end_of_test();
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) bad_count++;
        if (s !== e) $display("[ERR] %s expected %h seen %h", n, e, s);
    endtask
    // One request, offered for one cycle, then wait for its answer
    task automatic run(fci_pkg::fci_op_type o, logic [18:0] a, logic [7:0] d);
        int n;
        @(negedge mclk);
        req = '{op: o, addr: a, data: d};
        req_valid = 1;
        @(negedge mclk);
        req_valid = 0;
        for (n = 0; n < 3000 && resp_valid !== 1'b1; n++) @(negedge mclk);
        // A request that never answers counts as a mismatch
        chk("resp", 8'(resp_valid), 8'h01);
        rd = resp_data;
        er = resp_err;
    endtask
    task automatic t_idle;
        chk("ce_n", 8'(pins.ce_n), 8'h01);
        chk("bus_oe", 8'(pins.data_bus_oe), 8'h00);
        chk("ready", 8'(req_ready), 8'h01);
    endtask
    task automatic t_read_id;
        run(fci_pkg::OP_READ, 19'h7ff00, 8'h00);
        chk("blank", rd, 8'hff);
        run(fci_pkg::OP_READ_ID, 19'h0, 8'h00);
        chk("maker", rd, MK);
        run(fci_pkg::OP_READ_ID, 19'h1, 8'h00);
        chk("part", rd, PT);
    endtask
    task automatic t_prog;
        run(fci_pkg::OP_PROGRAM, 19'h12345, 8'h3c);
        chk("prog_err", 8'(er), 8'h00);
        run(fci_pkg::OP_PROGRAM, 19'h12445, 8'h5a);
        run(fci_pkg::OP_PROGRAM, 19'h12300, 8'ha5);
        run(fci_pkg::OP_READ, 19'h12345, 8'h00);
        chk("prog_rd", rd, 8'h3c);
    endtask
    task automatic t_erase;
        run(fci_pkg::OP_ERASE, 19'h123c7, 8'h00);
        chk("erase_err", 8'(er), 8'h00);
        run(fci_pkg::OP_READ, 19'h12300, 8'h00);
        chk("erased", rd, 8'hff);
        run(fci_pkg::OP_READ, 19'h12445, 8'h00);
        chk("kept", rd, 8'h5a);
    endtask
    task automatic t_abort;
        run(fci_pkg::OP_PROGRAM, 19'h12310, 8'h77);
        abort = 1;
        run(fci_pkg::OP_ERASE, 19'h12310, 8'h00);
        chk("abort_err", 8'(er), 8'h01);
        abort = 0;
        run(fci_pkg::OP_ERASE, 19'h12310, 8'h00);
        chk("again_err", 8'(er), 8'h00);
        run(fci_pkg::OP_RESET, 19'h0, 8'h00);
        run(fci_pkg::OP_READ, 19'h12445, 8'h00);
        chk("after_rst", rd, 8'h5a);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rstn = 1;
        t_idle();
        t_read_id();
        t_prog();
        t_erase();
        t_abort();
        end_of_test();
    end
endmodule
